/* core/rrd_check.sv */
// Combinational field checker for one release command
`timescale 1ns/1ps
module rrd_check
  import rrd_pkg::*;
(
  // Command and namespace state
  input  wire rrd_cmd_t    cmd,
  input  wire logic [7:0]  cur_kind,
  input  wire logic [63:0] host_key,
  // Verdict
  output rrd_res_t         res
);
  always_comb begin
    res = '{code: ST_SUCCESS, ok: 1'b0, do_release: 1'b0, do_clear: 1'b0};
    if (cmd.skip) begin
      res.code = ST_INV_CLASS;
    end else if (cmd.op != OP_RELEASE && cmd.op != OP_CLEAR) begin
      res.code = ST_INV_FIELD;
    end else if (cmd.key != host_key) begin
      res.code = ST_CONFLICT;
    end else if (cmd.op == OP_RELEASE && cmd.kind != cur_kind) begin
      res.code = ST_INV_FIELD;
    end else begin
      res.ok = 1'b1;
      res.do_release = (cmd.op == OP_RELEASE);
      res.do_clear = (cmd.op == OP_CLEAR);
    end
  end
endmodule

/* core/rrd_pkg.sv */
// Package: constants, types and behaviour list for the reservation release decoder
// Behaviour
// - Dword bits 2:0 select release (000b), clear (001b); others reserved.
// - Release carries reservation kind in bits 15:8, expected equal to current kind.
// - Kind mismatch on release fails with invalid-field status.
// - Skip-key-check bit 3 set rejects command with invalid-class status.
// - Skip bit clear: supplied held key compared with registered host key.
// - Every finished command posts a completion carrying its status.
// - Only dword 10 and the fetched structure are used; other fields reserved.
// - Successful clear increments the 32-bit wrapping generation count.
package rrd_pkg;
  localparam int OP_LSB = 0;
  localparam int OP_W = 3;
  localparam int SKIP_BIT = 3;
  localparam int KIND_LSB = 8;
  localparam int KIND_W = 8;
  localparam logic [2:0] OP_RELEASE = 3'h0;
  localparam logic [2:0] OP_CLEAR = 3'h1;
  localparam logic [7:0] KIND_NONE = 8'h00;
  localparam logic [31:0] GENERATION_RESET = 32'h0000_0000;
  localparam logic [63:0] KEY_RESET = 64'h0;
  // Completion status codes
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_INV_FIELD = 8'h02;
  localparam logic [7:0] ST_INV_CLASS = 8'h01;
  localparam logic [7:0] ST_CONFLICT = 8'h83;
  // APB map
  localparam logic [11:0] A_DW10 = 12'h000;
  localparam logic [11:0] A_KEYLO = 12'h004;
  localparam logic [11:0] A_KEYHI = 12'h008;
  localparam logic [11:0] A_CTRL = 12'h00c;
  localparam logic [11:0] A_STATUS = 12'h010;
  localparam logic [11:0] A_GENERATION = 12'h014;
  localparam logic [11:0] A_KIND = 12'h018;
  localparam logic [11:0] A_REGLO = 12'h01c;
  localparam logic [11:0] A_REGHI = 12'h020;
  localparam logic [11:0] A_COUNT = 12'h024;

  typedef struct packed {
    logic [2:0]  op;
    logic        skip;
    logic [7:0]  kind;
    logic [63:0] key;
  } rrd_cmd_t;

  typedef struct packed {
    logic [7:0] code;
    logic       ok;
    logic       do_release;
    logic       do_clear;
  } rrd_res_t;
endpackage

/* core/rrd_top.sv */
// APB-controlled reservation release decoder with completion posting
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module rrd_top
  import rrd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Completion entry
  output logic             cpl_valid,
  output logic [7:0]       cpl_status,
  // Namespace state
  output logic [31:0]      generation_count,
  output logic [7:0]       reservation_kind
);
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_POST} rrd_state_t;

  // Sequencer
  rrd_state_t  state_r;
  rrd_state_t  state_nxt;
  // Command inputs and the requesting host's registered key
  logic [31:0] dw10_r;
  logic [63:0] held_key_r;
  logic [63:0] reg_key_r;
  // Outcome bookkeeping
  logic [7:0]  last_status_r;
  logic        done_r;
  logic [15:0] count_r;
  // Decode of the command and of the bus
  rrd_cmd_t    cmd;
  rrd_res_t    res;
  logic        idle;
  logic        setup_ph;
  logic        wr;
  logic        rd;
  logic        cmd_wr;
  logic        go;
  logic        decide;
  logic        bad_addr;
  logic [31:0] rdata_nxt;

  assign idle = state_r == S_IDLE;
  assign setup_ph = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = setup_ph && !pwrite;
  // Command inputs are ignored while a command is in flight
  assign cmd_wr = wr && idle;
  assign go = cmd_wr && paddr == A_CTRL && pwdata[0];
  // The verdict is taken in the one cycle spent in the check state
  assign decide = state_r == S_CHECK;
  // Beyond the last register or off a word boundary
  assign bad_addr = paddr > A_COUNT || paddr[1:0] != 2'b00;

  // Only dword 10 and the fetched held key feed the decode
  assign cmd.op = dw10_r[OP_LSB +: OP_W];
  assign cmd.skip = dw10_r[SKIP_BIT];
  assign cmd.kind = dw10_r[KIND_LSB +: KIND_W];
  assign cmd.key = held_key_r;

  rrd_check u_check (
    .cmd      (cmd),
    .cur_kind (reservation_kind),
    .host_key (reg_key_r),
    .res      (res)
  );

  // Sequencer: idle, one cycle to decide, one cycle to post
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (go) begin
          state_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        state_nxt = S_POST;
      end
      S_POST: begin
        state_nxt = S_IDLE;
      end
      // The unused fourth code falls back to idle
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Command dword
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dw10_r <= 32'h0;
    end else if (cmd_wr && paddr == A_DW10) begin
      dw10_r <= pwdata;
    end
  end

  // Held key, low word in bits 31:0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_key_r <= KEY_RESET;
    end else if (cmd_wr) begin
      if (paddr == A_KEYLO) begin
        held_key_r[31:0] <= pwdata;
      end
      if (paddr == A_KEYHI) begin
        held_key_r[63:32] <= pwdata;
      end
    end
  end

  // Registered key of the requesting host, same word order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_key_r <= KEY_RESET;
    end else if (cmd_wr) begin
      if (paddr == A_REGLO) begin
        reg_key_r[31:0] <= pwdata;
      end
      if (paddr == A_REGHI) begin
        reg_key_r[63:32] <= pwdata;
      end
    end
  end

  // Current kind: dropped by a successful release or clear, else loaded by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reservation_kind <= KIND_NONE;
    end else if (decide) begin
      if (res.do_release || res.do_clear) begin
        reservation_kind <= KIND_NONE;
      end
    end else if (cmd_wr && paddr == A_KIND) begin
      reservation_kind <= pwdata[7:0];
    end
  end

  // Wraps silently; only a successful clear moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      generation_count <= GENERATION_RESET;
    end else if (decide && res.do_clear) begin
      generation_count <= generation_count + 32'h1;
    end
  end

  // Status of the last command and count of commands finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_status_r <= ST_SUCCESS;
      count_r <= 16'h0;
    end else if (decide) begin
      last_status_r <= res.code;
      count_r <= count_r + 16'h1;
    end
  end

  // Completion entry: a one-cycle strobe, the status holds until the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_valid <= 1'b0;
      cpl_status <= ST_SUCCESS;
    end else begin
      cpl_valid <= decide;
      if (decide) begin
        cpl_status <= res.code;
      end
    end
  end

  // Done flag: the set from a new completion wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (decide) begin
      done_r <= 1'b1;
    end else if (wr && paddr == A_STATUS && pwdata[0]) begin
      done_r <= 1'b0;
    end
  end

  // Read mux, decoded in the setup cycle so the word stands in the access cycle
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (paddr)
      A_DW10:       rdata_nxt = dw10_r;
      A_KEYLO:      rdata_nxt = held_key_r[31:0];
      A_KEYHI:      rdata_nxt = held_key_r[63:32];
      A_CTRL:       rdata_nxt = {31'h0, !idle};
      A_STATUS:     rdata_nxt = {23'h0, last_status_r, done_r};
      A_GENERATION: rdata_nxt = generation_count;
      A_KIND:       rdata_nxt = {24'h0, reservation_kind};
      A_REGLO:      rdata_nxt = reg_key_r[31:0];
      A_REGHI:      rdata_nxt = reg_key_r[63:32];
      A_COUNT:      rdata_nxt = {16'h0, count_r};
      default:      rdata_nxt = 32'h0;
    endcase
  end

  // Zero wait states: every setup cycle is answered in the cycle after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && bad_addr;
      if (rd) begin
        prdata <= rdata_nxt;
      end
    end
  end
endmodule

/* tb/reservation_release_decoder_bench.sv */
// Bench: commands via the host model, results checked from queues
`timescale 1ns/1ps
module reservation_release_decoder_bench;
  import rrd_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, cpl_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, generation_count, qr[$];
  logic [7:0]  cpl_status, reservation_kind, kd, qs[$];
  logic [63:0] k;
  logic        qx[$];
  int          n_fail = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  rrd_host host (.*);
  rrd_top dut (.*);
  task chk(input logic [31:0] e, g);
    num_checks++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cmd(input logic [31:0] dw, input logic [63:0] key, input logic [7:0] st);
    host.xfer(1'b1, A_KEYLO, key[31:0]);
    host.xfer(1'b1, A_KEYHI, key[63:32]);
    host.xfer(1'b1, A_DW10, dw);
    qs.push_back(st);
    host.xfer(1'b1, A_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    qr.push_back(e);
    qx.push_back(a > A_COUNT);
    host.xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (cpl_valid) chk(qs.pop_front(), cpl_status);
    if (pready && !pwrite && qr.size() > 0) begin
      chk(qr.pop_front(), prdata);
      chk({31'h0, qx.pop_front()}, {31'h0, pslverr});
    end
  end
  initial begin
    void'($urandom(32'hc6f359d5));
    k = {$urandom, $urandom};
    kd = 8'($urandom_range(255, 1));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    host.xfer(1'b1, A_REGLO, k[31:0]);
    host.xfer(1'b1, A_REGHI, k[63:32]);
    host.xfer(1'b1, A_KIND, {24'h0, kd});
    cmd({16'h0, ~kd, 8'h00}, k, ST_INV_FIELD);
    cmd(32'h8, k, ST_INV_CLASS);
    cmd({16'h0, kd, 8'h00}, ~k, ST_CONFLICT);
    for (int i = 2; i < 8; i++) cmd({16'h0, kd, 8'h00} | 32'(i), k, ST_INV_FIELD);
    rd(A_KIND, {24'h0, kd});
    cmd({16'h0, kd, 8'h00}, k, ST_SUCCESS);
    rd(A_KIND, 32'h0);
    rd(A_GENERATION, 32'h0);
    host.xfer(1'b1, A_KIND, {24'h0, kd});
    cmd(32'h1, k, ST_SUCCESS);
    rd(A_GENERATION, 32'h1);
    rd(A_COUNT, 32'h0000000b);
    rd(12'h028, 32'h0);
    chk(32'h0, qs.size());
    summarize;
  end
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
endmodule

/* tb/rrd_asserts.sv */
// Port checker for the release decoder
`timescale 1ns/1ps
module rrd_asserts
  import rrd_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Completion and namespace state
  input wire logic        cpl_valid,
  input wire logic [7:0]  cpl_status,
  input wire logic [31:0] generation_count,
  input wire logic [7:0]  reservation_kind
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = psel && penable && pwrite && paddr == A_CTRL && pwdata[0];
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready");
  a_bad_addr: assert property (pready && paddr > A_COUNT |-> pslverr) else $error("no slverr");
  a_cpl_cause: assert property (cpl_valid |-> $past(go, 2)) else $error("stray cpl");
  a_cpl_pulse: assert property (cpl_valid |=> !cpl_valid) else $error("long cpl");
  a_generation_step: assert property ($changed(generation_count) |-> cpl_valid && cpl_status == ST_SUCCESS
    && generation_count == $past(generation_count) + 32'h1) else $error("generation step");
  a_generation_hold: assert property (cpl_valid && cpl_status != ST_SUCCESS |-> $stable(generation_count))
    else $error("generation moved");
  a_kind_done: assert property (cpl_valid && cpl_status == ST_SUCCESS |-> reservation_kind == KIND_NONE)
    else $error("kind kept");
  a_kind_keep: assert property (cpl_valid && cpl_status != ST_SUCCESS |-> $stable(reservation_kind))
    else $error("kind moved");
  c_skip: cover property (cpl_valid && cpl_status == ST_INV_CLASS);
  c_conflict: cover property (cpl_valid && cpl_status == ST_CONFLICT);
  c_generation: cover property ($changed(generation_count));
endmodule
bind rrd_top rrd_asserts u_chk (.*);

/* tb/rrd_host.sv */
// Host model: APB master loading dword 10 and the held key
`timescale 1ns/1ps
module rrd_host (
  // Clock and slave answer
  input  wire logic        pclk,
  input  wire logic        pready,
  // Request
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h0,
  output logic [31:0]      pwdata  = 32'h0
);
  // Released address and data go inverted so a stale value is never mistaken for live
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
